//--- fws_cfg.svh
/*
  offsets, field positions, response codes and timing counts of the
  flash write-status poller.
  assumes a 125 mhz system clock and a byte-wide parallel nor flash.
*/
`ifndef FWS_CFG_SVH
`define FWS_CFG_SVH

`define FWS_REG_CTRL     8'h00
`define FWS_REG_ADDR     8'h04
`define FWS_REG_WDATA    8'h08
`define FWS_REG_STATUS   8'h0c

`define FWS_CTRL_OP_LSB  0
`define FWS_ST_BUSY      0
`define FWS_ST_DONE      1
`define FWS_ST_FAIL      2
`define FWS_ST_RDY       3
`define FWS_ST_ETIMER    4
`define FWS_ST_TLIMIT    5
`define FWS_ST_TOGB      6
`define FWS_ST_BYTE_LSB  8

`define FWS_BIT_POLL     7
`define FWS_BIT_TOGA     6
`define FWS_BIT_TLIMIT   5
`define FWS_BIT_ETIMER   3
`define FWS_BIT_TOGB     2

`define FWS_RESP_OKAY    2'b00
`define FWS_RESP_SLVERR  2'b10

`define FWS_CLK_NS       8
`define FWS_T_RC_NS      70
`define FWS_T_OEH_NS     10
`define FWS_T_WP_NS      35
`define FWS_SYNC_CYC     2
`define FWS_RC_CYC   ((`FWS_T_RC_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_RD_CYC   (`FWS_RC_CYC + `FWS_SYNC_CYC)
`define FWS_OEH_CYC  ((`FWS_T_OEH_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)
`define FWS_WP_CYC   ((`FWS_T_WP_NS + `FWS_CLK_NS - 1) / `FWS_CLK_NS)

`endif

//--- fws_flash_model.sv
/*
  behavioural nor flash: program, status reads, reset command.
  assumes the bench sets busy length, erase and protect flags.
*/
`default_nettype none
module fws_flash_model (
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic        drv,
  input  wire logic [19:0] addr,
  input  wire logic [7:0]  dq_in,
  output logic [7:0]       dq,
  output logic             rb_low
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [16];
  int         busy = 0, pgm_reads = 2;
  logic       fail = 0, erase = 0, prot = 0, tog_a = 0, tog_b = 0;
  logic       susp = 0, run;
  logic [7:0] last = 8'h00, wbyte = 8'h00, stat, rdv;
  initial foreach (mem[i]) mem[i] = 8'hff;
  // addresses 8 to 15 form the sector under erase
  assign run = busy != 0 && !susp;
  assign stat = {erase ? susp : ~wbyte[7], tog_a, fail, 1'b0, erase,
                 tog_b, 2'b00};
  // status while busy, data outside a suspended sector
  assign rdv = (run || fail || (susp && addr[3])) ? stat : mem[addr[3:0]];
  // released bus shows inverse, not stale data
  assign dq = (!ce_n && !oe_n) ? rdv : ~last;
  // busy from last write strobe, released in suspend
  assign rb_low = run || fail;
  always @(posedge we_n) if (drv === 1'b1) begin
    // while erasing only suspend is taken
    // otherwise reset returns to array read
    if (erase && !fail) begin
      if (dq_in == 8'hb0) susp = 1;
    end else if (dq_in == 8'hf0) begin
      busy = 0;
      fail = 0;
      erase = 0;
      susp = 0;
    end else begin
      wbyte = dq_in;
      busy = pgm_reads;
      // one over zero halts with limit flag
      if ((dq_in & ~mem[addr[3:0]]) != 0) fail = 1;
      else if (!prot) mem[addr[3:0]] = dq_in;
    end
  end
  always @(posedge oe_n) begin
    last = rdv;
    if (run || fail) tog_a = ~tog_a;
    if (erase && addr[3]) tog_b = ~tog_b;
    if (run && !fail) begin
      busy--;
      if (busy == 0) erase = 0;
    end
  end
endmodule
`default_nettype wire

//--- fws_flash_status_host.sv
/*
  host controller for a parallel nor flash: single write and read bus
  cycles plus the toggle-bit completion poll, ordered over axi4-lite.
  assumes an asynchronous byte-wide flash on pins and a pull-up on the
  ready/busy line.
*/
// Design decisions made here: the address map and register access over AXI4-Lite.
// Function
// RL1 - busy line low while embedded operation runs
// RL2 - busy line valid after last write strobe
// RL3 - toggle bit a flips each status read
// RL4 - toggle bit a readable at any address
// RL5 - all-protected erase toggles briefly then stops
// RL6 - protected program toggles briefly then stops
// RL7 - protected sectors skipped in partial erase
// RL8 - erase suspend stops toggle bit a
// RL9 - toggle bit b flips in erasing sectors
// RL10 - read status twice, compare toggle bit
// RL11 - toggling with limit flag: recheck, fail
// RL12 - resumed polling restarts with double read
// RL13 - limit flag high marks failed operation
// RL14 - programming zero to one hits limit
// RL15 - after failure write the reset command
// RL16 - erase timer flag rises at time-out end
// RL17 - timer ignorable if commands under 50us
// RL18 - after timer expiry only suspend accepted
// RL19 - check timer before and after commands
// RL20 - status reads use a valid address
// RL21 - poll bit shows complement until done
// RL22 - suspended reads outside sector give data
`include "fws_cfg.svh"
`default_nettype none
module fws_flash_status_host #(
  parameter int        AW        = 20,
  parameter logic [7:0] RESET_CMD = 8'hf0
) (
  input  wire logic              CLOCK_I,
  input  wire logic              NRST_I,
  input  wire logic [7:0]        AWADDR_I,
  input  wire logic              AWVALID_I,
  output logic                   AWREADY_O,
  input  wire logic [31:0]       WDATA_I,
  input  wire logic [3:0]        WSTRB_I,
  input  wire logic              WVALID_I,
  output logic                   WREADY_O,
  output logic [1:0]             BRESP_O,
  output logic                   BVALID_O,
  input  wire logic              BREADY_I,
  input  wire logic [7:0]        ARADDR_I,
  input  wire logic              ARVALID_I,
  output logic                   ARREADY_O,
  output logic [31:0]            RDATA_O,
  output logic [1:0]             RRESP_O,
  output logic                   RVALID_O,
  input  wire logic              RREADY_I,
  output logic [AW-1:0]          FLASH_ADDR_O,
  input  wire logic [7:0]        FLASH_DQ_I,
  output logic [7:0]             FLASH_DQ_O,
  output logic                   FLASH_DQ_OE_O,
  output logic                   FLASH_CE_N_O,
  output logic                   FLASH_OE_N_O,
  output logic                   FLASH_WE_N_O,
  input  wire logic              READY_BUSY_N_I
);
  import fws_pkg::*;

  // pin synchronisers: only stage two feeds logic
  logic [7:0]  dq_s1;
  logic [7:0]  dq_s2;
  logic        rb_s1;
  logic        rb_s2;

  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      dq_s1 <= 8'h00;
      dq_s2 <= 8'h00;
      rb_s1 <= 1'b1;
      rb_s2 <= 1'b1;
    end else begin
      dq_s1 <= FLASH_DQ_I;
      dq_s2 <= dq_s1;
      rb_s1 <= READY_BUSY_N_I;
      rb_s2 <= rb_s1;
    end
  end

  // register bus state
  logic          aw_full, next_aw_full;
  logic [7:0]    aw_addr, next_aw_addr;
  logic          w_full, next_w_full;
  logic [31:0]   w_data, next_w_data;
  logic [3:0]    w_strb, next_w_strb;
  logic          bvalid, next_bvalid;
  logic [1:0]    bresp, next_bresp;
  logic          rvalid, next_rvalid;
  logic [31:0]   rdata, next_rdata;
  logic [1:0]    rresp, next_rresp;
  logic [31:0]   addr_reg, next_addr_reg;
  logic [7:0]    wdata_reg, next_wdata_reg;
  logic          go, next_go;
  fws_op_e       go_op, next_go_op;

  // sequencer state
  fws_state_e    state, next_state;
  fws_op_e       op, next_op;
  logic [7:0]    cnt, next_cnt;
  logic [7:0]    first, next_first;
  logic [7:0]    last, next_last;
  logic          have, next_have;
  logic          recheck, next_recheck;
  logic          rst_cmd, next_rst_cmd;
  logic          done, next_done;
  logic          fail, next_fail;
  logic          tog_b, next_tog_b;
  logic [AW-1:0] fa, next_fa;
  logic [7:0]    fdq, next_fdq;
  logic          fdq_oe, next_fdq_oe;
  logic          ce_n, next_ce_n;
  logic          oe_n, next_oe_n;
  logic          we_n, next_we_n;

  logic [31:0]   status;
  logic          busy;

  assign busy = (state != FWS_IDLE) || go;

  always_comb begin
    status = 32'h0000_0000;
    status[`FWS_ST_BUSY]   = busy;
    status[`FWS_ST_DONE]   = done;
    status[`FWS_ST_FAIL]   = fail;
    // RL1 busy line seen
    status[`FWS_ST_RDY]    = rb_s2;
    // RL19 timer flag shown
    // RL17 timer left to software
    status[`FWS_ST_ETIMER] = last[`FWS_BIT_ETIMER];
    status[`FWS_ST_TLIMIT] = last[`FWS_BIT_TLIMIT];
    status[`FWS_ST_TOGB]   = tog_b;
    status[`FWS_ST_BYTE_LSB +: 8] = last;
  end

  assign AWREADY_O = !aw_full && !bvalid;
  assign WREADY_O  = !w_full && !bvalid;
  assign BVALID_O  = bvalid;
  assign BRESP_O   = bresp;
  assign ARREADY_O = !rvalid;
  assign RVALID_O  = rvalid;
  assign RDATA_O   = rdata;
  assign RRESP_O   = rresp;

  always_comb begin
    logic [7:0] wa;
    logic [7:0] ra;
    wa = {aw_addr[7:2], 2'b00};
    ra = {ARADDR_I[7:2], 2'b00};
    next_aw_full   = aw_full;
    next_aw_addr   = aw_addr;
    next_w_full    = w_full;
    next_w_data    = w_data;
    next_w_strb    = w_strb;
    next_bvalid    = bvalid;
    next_bresp     = bresp;
    next_rvalid    = rvalid;
    next_rdata     = rdata;
    next_rresp     = rresp;
    next_addr_reg  = addr_reg;
    next_wdata_reg = wdata_reg;
    next_go        = go && (state != FWS_IDLE);
    next_go_op     = go_op;
    if (AWVALID_I && AWREADY_O) begin
      next_aw_full = 1'b1;
      next_aw_addr = AWADDR_I;
    end
    if (WVALID_I && WREADY_O) begin
      next_w_full = 1'b1;
      next_w_data = WDATA_I;
      next_w_strb = WSTRB_I;
    end
    if (aw_full && w_full) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = `FWS_RESP_OKAY;
      case (wa)
        `FWS_REG_CTRL: begin
          // orders while busy are dropped: one flash cycle at a time
          if (w_strb[0] && !busy && (w_data[1:0] != 2'b00)) begin
            next_go    = 1'b1;
            next_go_op = fws_op_e'(w_data[`FWS_CTRL_OP_LSB +: 2]);
          end
        end
        `FWS_REG_ADDR: begin
          for (int i = 0; i < 4; i++) begin
            if (w_strb[i]) begin
              next_addr_reg[i*8 +: 8] = w_data[i*8 +: 8];
            end
          end
        end
        `FWS_REG_WDATA: begin
          if (w_strb[0]) begin
            next_wdata_reg = w_data[7:0];
          end
        end
        `FWS_REG_STATUS: begin
          next_bresp = `FWS_RESP_OKAY;
        end
        default: begin
          next_bresp = `FWS_RESP_SLVERR;
        end
      endcase
    end
    if (bvalid && BREADY_I) begin
      next_bvalid = 1'b0;
    end
    if (rvalid && RREADY_I) begin
      next_rvalid = 1'b0;
    end
    if (ARVALID_I && ARREADY_O) begin
      next_rvalid = 1'b1;
      next_rresp  = `FWS_RESP_OKAY;
      case (ra)
        `FWS_REG_CTRL:   next_rdata = 32'h0000_0000;
        `FWS_REG_ADDR:   next_rdata = addr_reg;
        `FWS_REG_WDATA:  next_rdata = {24'h00_0000, wdata_reg};
        `FWS_REG_STATUS: next_rdata = status;
        default: begin
          next_rdata = 32'h0000_0000;
          next_rresp = `FWS_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      aw_full   <= 1'b0;
      aw_addr   <= 8'h00;
      w_full    <= 1'b0;
      w_data    <= 32'h0000_0000;
      w_strb    <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= 2'b00;
      rvalid    <= 1'b0;
      rdata     <= 32'h0000_0000;
      rresp     <= 2'b00;
      addr_reg  <= 32'h0000_0000;
      wdata_reg <= 8'h00;
      go        <= 1'b0;
      go_op     <= FWS_OP_NONE;
    end else begin
      aw_full   <= next_aw_full;
      aw_addr   <= next_aw_addr;
      w_full    <= next_w_full;
      w_data    <= next_w_data;
      w_strb    <= next_w_strb;
      bvalid    <= next_bvalid;
      bresp     <= next_bresp;
      rvalid    <= next_rvalid;
      rdata     <= next_rdata;
      rresp     <= next_rresp;
      addr_reg  <= next_addr_reg;
      wdata_reg <= next_wdata_reg;
      go        <= next_go;
      go_op     <= next_go_op;
    end
  end

  always_comb begin
    next_state   = state;
    next_op      = op;
    next_cnt     = cnt;
    next_first   = first;
    next_last    = last;
    next_have    = have;
    next_recheck = recheck;
    next_rst_cmd = rst_cmd;
    next_done    = done;
    next_fail    = fail;
    next_tog_b   = tog_b;
    next_fa      = fa;
    case (state)
      FWS_IDLE: begin
        if (go) begin
          next_op      = go_op;
          next_done    = 1'b0;
          next_fail    = 1'b0;
          // RL12 fresh double read
          next_have    = 1'b0;
          next_recheck = 1'b0;
          next_cnt     = 8'h00;
          // RL20 address from software
          next_fa      = addr_reg[AW-1:0];
          next_state   = (go_op == FWS_OP_WRITE) ? FWS_WR : FWS_RD;
        end
      end
      FWS_WR: begin
        next_cnt = cnt + 8'h01;
        if (cnt == 8'(`FWS_WP_CYC - 1)) begin
          next_state = FWS_WR_HOLD;
        end
      end
      FWS_WR_HOLD: begin
        next_cnt   = 8'h00;
        next_state = FWS_GAP;
      end
      FWS_RD: begin
        next_cnt = cnt + 8'h01;
        // sample late: the byte has crossed both sync stages
        if (cnt == 8'(`FWS_RD_CYC - 1)) begin
          next_last  = dq_s2;
          next_cnt   = 8'h00;
          next_state = FWS_GAP;
        end
      end
      FWS_GAP: begin
        next_cnt = cnt + 8'h01;
        if (cnt == 8'(`FWS_OEH_CYC - 1)) begin
          next_cnt   = 8'h00;
          next_state = FWS_EVAL;
        end
      end
      FWS_EVAL: begin
        next_cnt   = 8'h00;
        next_state = FWS_IDLE;
        next_done  = 1'b1;
        if (rst_cmd) begin
          next_rst_cmd = 1'b0;
        end else if (op == FWS_OP_POLL) begin
          if (!have) begin
            // RL10 second read
            next_first = last;
            next_have  = 1'b1;
            next_done  = 1'b0;
            next_state = FWS_RD;
          end else begin
            // RL9 bit b flip noted
            next_tog_b = last[`FWS_BIT_TOGB] ^ first[`FWS_BIT_TOGB];
            if (last[`FWS_BIT_TOGA] == first[`FWS_BIT_TOGA]) begin
              // RL10 finished cleanly
              next_fail = 1'b0;
            end else if (recheck) begin
              // RL15 reset command
              next_fail    = 1'b1;
              next_rst_cmd = 1'b1;
              next_done    = 1'b0;
              next_state   = FWS_WR;
            end else begin
              // RL11 limit flag recheck
              next_recheck = last[`FWS_BIT_TLIMIT];
              next_first   = last;
              next_done    = 1'b0;
              next_state   = FWS_RD;
            end
          end
        end
      end
      default: begin
        next_state = FWS_IDLE;
      end
    endcase
    next_ce_n   = !(next_state == FWS_WR || next_state == FWS_WR_HOLD ||
                    next_state == FWS_RD);
    next_oe_n   = (next_state != FWS_RD);
    next_we_n   = (next_state != FWS_WR);
    next_fdq_oe = (next_state == FWS_WR || next_state == FWS_WR_HOLD);
    next_fdq    = next_rst_cmd ? RESET_CMD : wdata_reg;
  end

  always_ff @(posedge CLOCK_I) begin
    if (!NRST_I) begin
      state   <= FWS_IDLE;
      op      <= FWS_OP_NONE;
      cnt     <= 8'h00;
      first   <= 8'h00;
      last    <= 8'h00;
      have    <= 1'b0;
      recheck <= 1'b0;
      rst_cmd <= 1'b0;
      done    <= 1'b0;
      fail    <= 1'b0;
      tog_b   <= 1'b0;
      fa      <= '0;
      fdq     <= 8'h00;
      fdq_oe  <= 1'b0;
      ce_n    <= 1'b1;
      oe_n    <= 1'b1;
      we_n    <= 1'b1;
    end else begin
      state   <= next_state;
      op      <= next_op;
      cnt     <= next_cnt;
      first   <= next_first;
      last    <= next_last;
      have    <= next_have;
      recheck <= next_recheck;
      rst_cmd <= next_rst_cmd;
      done    <= next_done;
      fail    <= next_fail;
      tog_b   <= next_tog_b;
      fa      <= next_fa;
      fdq     <= next_fdq;
      fdq_oe  <= next_fdq_oe;
      ce_n    <= next_ce_n;
      oe_n    <= next_oe_n;
      we_n    <= next_we_n;
    end
  end

  assign FLASH_ADDR_O  = fa;
  assign FLASH_DQ_O    = fdq;
  assign FLASH_DQ_OE_O = fdq_oe;
  assign FLASH_CE_N_O  = ce_n;
  assign FLASH_OE_N_O  = oe_n;
  assign FLASH_WE_N_O  = we_n;
endmodule
`default_nettype wire

//--- fws_flash_status_host_asserts.sv
/*
  axi and flash pin timing checker of the write-status host.
  assumes binding to fws_flash_status_host, one clock domain.
*/
`default_nettype none
module fws_host_chk #(parameter int AW = 20) (
  input wire logic          CLOCK_I,
  input wire logic          NRST_I,
  input wire logic          AWVALID_I,
  input wire logic          AWREADY_O,
  input wire logic          WVALID_I,
  input wire logic          WREADY_O,
  input wire logic          BVALID_O,
  input wire logic          BREADY_I,
  input wire logic          ARVALID_I,
  input wire logic          ARREADY_O,
  input wire logic          RVALID_O,
  input wire logic          RREADY_I,
  input wire logic [1:0]    BRESP_O,
  input wire logic [31:0]   RDATA_O,
  input wire logic [AW-1:0] FLASH_ADDR_O,
  input wire logic          FLASH_DQ_OE_O,
  input wire logic          FLASH_CE_N_O,
  input wire logic          FLASH_OE_N_O,
  input wire logic          FLASH_WE_N_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!NRST_I);
  AST_B_HOLD: assert property (
    BVALID_O && !BREADY_I |=> BVALID_O && $stable(BRESP_O))
    else $error("write answer dropped");
  AST_R_HOLD: assert property (
    RVALID_O && !RREADY_I |=> RVALID_O && $stable(RDATA_O))
    else $error("read answer dropped");
  AST_R_AFTER_AR: assert property (ARVALID_I && ARREADY_O |=> RVALID_O)
    else $error("read answer late");
  AST_B_AFTER_AW: assert property (
    AWVALID_I && AWREADY_O && WVALID_I && WREADY_O |-> ##2 BVALID_O)
    else $error("write answer late");
  AST_AR_BLOCK: assert property (RVALID_O |-> !ARREADY_O)
    else $error("read taken while answer pending");
  AST_WE_PULSE: assert property (
    $fell(FLASH_WE_N_O) |->
    (!FLASH_WE_N_O && !FLASH_CE_N_O && FLASH_DQ_OE_O)[*5] ##1
    (FLASH_WE_N_O && !FLASH_CE_N_O && FLASH_DQ_OE_O) ##1
    (FLASH_CE_N_O && !FLASH_DQ_OE_O))
    else $error("bad write strobe");
  AST_RD_STROBE: assert property (
    $fell(FLASH_OE_N_O) |-> !FLASH_CE_N_O && !FLASH_DQ_OE_O ##10
    !FLASH_OE_N_O ##1 (FLASH_OE_N_O && FLASH_CE_N_O)[*2])
    else $error("bad read strobe");
  AST_ADDR_HELD: assert property (
    !FLASH_OE_N_O && !$fell(FLASH_OE_N_O) |-> $stable(FLASH_ADDR_O))
    else $error("address moved in read");
endmodule
bind fws_flash_status_host fws_host_chk #(.AW(AW)) u_chk (
  .CLOCK_I(CLOCK_I), .NRST_I(NRST_I), .AWVALID_I(AWVALID_I),
  .AWREADY_O(AWREADY_O), .WVALID_I(WVALID_I), .WREADY_O(WREADY_O),
  .BVALID_O(BVALID_O), .BREADY_I(BREADY_I), .ARVALID_I(ARVALID_I),
  .ARREADY_O(ARREADY_O), .RVALID_O(RVALID_O), .RREADY_I(RREADY_I),
  .BRESP_O(BRESP_O), .RDATA_O(RDATA_O), .FLASH_ADDR_O(FLASH_ADDR_O),
  .FLASH_DQ_OE_O(FLASH_DQ_OE_O), .FLASH_CE_N_O(FLASH_CE_N_O),
  .FLASH_OE_N_O(FLASH_OE_N_O), .FLASH_WE_N_O(FLASH_WE_N_O));
`default_nettype wire

//--- fws_pkg.sv
/*
  types of the flash write-status poller.
  assumes fws_cfg.svh supplies the numeric constants.
*/
`default_nettype none
package fws_pkg;
  typedef enum logic [1:0] {
    FWS_OP_NONE,
    FWS_OP_WRITE,
    FWS_OP_READ,
    FWS_OP_POLL
  } fws_op_e;

  typedef enum logic [2:0] {
    FWS_IDLE,
    FWS_WR,
    FWS_WR_HOLD,
    FWS_RD,
    FWS_GAP,
    FWS_EVAL
  } fws_state_e;
endpackage
`default_nettype wire

//--- test_fws_flash_status_host.sv
/*
  self-checking bench of the write-status host.
  assumes the flash model on the pins and its rb_low output inverted onto ready/busy.
*/
`default_nettype none
module test_fws_flash_status_host;
  timeunit 1ns;
  timeprecision 1ps;
  import fws_pkg::*;
  logic        clk = 0, nrst = 0, awv = 0, wv = 0, arv = 0;
  logic        brdy = 1, rrdy = 1;
  logic [7:0]  awa = 0, ara = 0, b1;
  logic [31:0] wd = 0, rdat, st;
  logic [1:0]  resp;
  wire         awr, wr, bv, arr, rv, dq_oe, ce_n, oe_n, we_n, rb_low;
  wire [1:0]   br, rr;
  wire [31:0]  rd;
  wire [19:0]  fa;
  wire [7:0]   dq_o, fl_dq, dq;
  int          miscompares = 0, n_tests = 0, cyc = 0;
  int          hold = 0;
  assign dq = dq_oe ? dq_o : fl_dq;
  fws_flash_status_host DUT (.CLOCK_I(clk), .NRST_I(nrst),
    .AWADDR_I(awa), .AWVALID_I(awv), .AWREADY_O(awr), .WDATA_I(wd),
    .WSTRB_I(4'hf), .WVALID_I(wv), .WREADY_O(wr), .BRESP_O(br),
    .BVALID_O(bv), .BREADY_I(brdy), .ARADDR_I(ara), .ARVALID_I(arv),
    .ARREADY_O(arr), .RDATA_O(rd), .RRESP_O(rr), .RVALID_O(rv),
    .RREADY_I(rrdy), .FLASH_ADDR_O(fa), .FLASH_DQ_I(dq),
    .FLASH_DQ_O(dq_o), .FLASH_DQ_OE_O(dq_oe), .FLASH_CE_N_O(ce_n),
    .FLASH_OE_N_O(oe_n), .FLASH_WE_N_O(we_n), .READY_BUSY_N_I(!rb_low));
  fws_flash_model u_flash (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .drv(dq_oe), .addr(fa), .dq_in(dq), .dq(fl_dq), .rb_low(rb_low));
  initial forever #4 clk = ~clk;
  task automatic wrap_up;
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s exp %h got %h", nm, exp, got);
    end
  endtask
  // hold keeps bready or rready low a while, so answers must stand
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic pa, pw;
    pa = 1;
    pw = 1;
    brdy <= (hold == 0);
    awa <= a;
    wd <= d;
    awv <= 1;
    wv <= 1;
    while (pa || pw) begin
      @(posedge clk);
      if (pa && awr) begin
        pa = 0;
        awv <= 0;
      end
      if (pw && wr) begin
        pw = 0;
        wv <= 0;
      end
    end
    repeat (hold) @(posedge clk);
    brdy <= 1;
    do @(posedge clk); while (bv !== 1'b1);
    resp = br;
  endtask
  task automatic axr(input logic [7:0] a);
    rrdy <= (hold == 0);
    ara <= a;
    arv <= 1;
    do @(posedge clk); while (arr !== 1'b1);
    arv <= 0;
    repeat (hold) @(posedge clk);
    rrdy <= 1;
    do @(posedge clk); while (rv !== 1'b1);
    rdat = rd;
    resp = rr;
  endtask
  task automatic op(input fws_op_e c, input logic [7:0] a, d);
    axw(8'h04, {24'h0, a});
    axw(8'h08, {24'h0, d});
    axw(8'h00, {30'h0, c});
    repeat (2) @(posedge clk);
    do axr(8'h0c); while (rdat[0] !== 1'b0);
    st = rdat;
  endtask
  task automatic t_regs;
    axr(8'h0c);
    chk("status reset", rdat, 32'h8);
    hold = 3;
    axr(8'h10);
    chk("rresp", resp, 32'h2);
    chk("rdata", rdat, 32'h0);
    axw(8'h14, 32'h1);
    chk("bresp", resp, 32'h2);
    hold = 0;
  endtask
  task automatic t_prog;
    u_flash.pgm_reads = 3;
    op(FWS_OP_WRITE, 8'h03, 8'h5a);
    axr(8'h0c);
    chk("pin busy", rdat[3], 32'h0);
    op(FWS_OP_POLL, 8'h03, 8'h00);
    chk("poll state", st[2:0], 32'h2);
    chk("poll byte", st[15:8], 32'h5a);
    chk("array", u_flash.mem[3], 32'h5a);
    chk("pin ready", st[3], 32'h1);
  endtask
  task automatic t_fail;
    u_flash.pgm_reads = 2;
    op(FWS_OP_WRITE, 8'h03, 8'hff);
    op(FWS_OP_POLL, 8'h03, 8'h00);
    chk("fail state", st[2:0], 32'h6);
    chk("limit", st[5], 32'h1);
    chk("reset cmd", u_flash.fail, 32'h0);
    op(FWS_OP_READ, 8'h03, 8'h00);
    chk("kept", st[15:8], 32'h5a);
  endtask
  task automatic t_prot;
    u_flash.prot = 1;
    op(FWS_OP_WRITE, 8'h05, 8'h00);
    op(FWS_OP_POLL, 8'h05, 8'h00);
    chk("prot state", st[2:0], 32'h2);
    chk("prot cell", u_flash.mem[5], 32'hff);
    u_flash.prot = 0;
  endtask
  task automatic t_erase;
    u_flash.erase = 1;
    u_flash.busy = 4;
    op(FWS_OP_READ, 8'h08, 8'h00);
    b1 = st[15:8];
    op(FWS_OP_READ, 8'h08, 8'h00);
    chk("tog b", b1[2] ^ st[10], 32'h1);
    chk("tog a", b1[6] ^ st[14], 32'h1);
    chk("erase poll", b1[7], 32'h0);
    chk("timer", st[4], 32'h1);
    chk("pin erase", st[3], 32'h0);
    op(FWS_OP_POLL, 8'h08, 8'h00);
    chk("erase done", st[2:0], 32'h2);
  endtask
  task automatic t_susp;
    u_flash.erase = 1;
    u_flash.busy = 4;
    op(FWS_OP_WRITE, 8'h09, 8'h00);
    chk("ignored", u_flash.mem[9], 32'hff);
    op(FWS_OP_WRITE, 8'h08, 8'hb0);
    op(FWS_OP_POLL, 8'h08, 8'h00);
    chk("susp poll", st[2:0], 32'h2);
    chk("susp tog b", st[6], 32'h1);
    chk("susp pin", st[3], 32'h1);
    op(FWS_OP_READ, 8'h03, 8'h00);
    chk("susp data", st[15:8], 32'h5a);
    u_flash.susp = 0;
    u_flash.busy = 0;
    u_flash.erase = 0;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1;
    @(posedge clk);
    t_regs();
    t_prog();
    t_fail();
    t_prot();
    t_erase();
    t_susp();
    wrap_up();
  end
endmodule
`default_nettype wire
